// >>> pds_access_map.svh
// pds_access_map.svh: offsets, field positions, reset values, fixed bounds
// assumes: included by the design only, bare name only
`ifndef PDS_ACCESS_MAP_SVH
`define PDS_ACCESS_MAP_SVH

// ----------------------------------------------------------------
// register offsets (byte addresses, one 32-bit word each)
// ----------------------------------------------------------------
`define PDS_OFS_CORE_CTRL 8'h00
`define PDS_OFS_WIN_PAGE 8'h04
`define PDS_OFS_TBL_PAGE 8'h08
`define PDS_OFS_MOD_START 8'h0C
`define PDS_OFS_MOD_END 8'h10
`define PDS_OFS_STATUS 8'h14

// ----------------------------------------------------------------
// core control fields and reset values
// ----------------------------------------------------------------
`define PDS_CC_WIN_EN 0
`define PDS_CC_XMOD_EN 1
`define PDS_CC_YMOD_EN 2
`define PDS_CC_BREV_EN 3
`define PDS_CC_RESET 4'h0
`define PDS_PAGE_RESET 8'h00
`define PDS_MOD_RESET 16'h0000

// ----------------------------------------------------------------
// fixed x/y boundary and cycle figures
// ----------------------------------------------------------------
`define PDS_Y_LO 16'h1800
`define PDS_Y_HI 16'h1FFF
`define PDS_WIN_EXTRA_FAST 2'h1
`define PDS_WIN_EXTRA_SLOW 2'h2
`define PDS_RPT_EXTRA_EDGE 2'h2

`endif

// >>> pds_pkg.sv
// pds_pkg.sv: types shared by the access logic and its bench
// assumes: nothing beyond the map header
package pds_pkg;
  // access kinds issued by the execution pipeline
  typedef enum logic [2:0] {
    PDS_K_DRD = 3'h0,
    PDS_K_DWR = 3'h1,
    PDS_K_MAC = 3'h2,
    PDS_K_TRL = 3'h3,
    PDS_K_TRH = 3'h4,
    PDS_K_TWL = 3'h5,
    PDS_K_TWH = 3'h6
  } pds_kind_t;

  // sequencer states, one-hot
  typedef enum logic [1:0] {
    PDS_S_IDLE = 2'b01,
    PDS_S_WAIT = 2'b10
  } pds_state_t;
endpackage

// >>> pds_access.sv
// pds_access.sv: program/data space access logic of the signal core
// assumes: pipeline and apb master on sys_clk, synchronous high reset
//
// Notes on behaviour
// - program words 24 bits, address steps two
// - two 16-bit lanes: low word, high byte
// - low word table read returns bits 15:0
// - low byte table read picks byte select
// - high word read: bits 23:16, upper zero
// - high byte read: select one gives zero
// - window when address msb and enable set
// - window address: page plus low 15 bits
// - window reads return low 16 bits only
// - window suspended during table accesses
// - window outside repeat: one or two extra
// - repeat edges two extra, else none
// - mac x region excludes y block
// - mac reads x and y concurrently
// - unimplemented or wrong region reads zero
// - all data writes via x write bus
// - modulo in x and y, bit-reverse x writes
// - 16-bit byte addresses, 16-bit words
// - x/y boundary fixed, not programmable
// - table address from page and data address
//
// Decided for this implementation: the APB interface to the registers and the address map.
`include "pds_access_map.svh"
`timescale 1ns/1ns
`default_nettype none

module pds_access #(
  parameter int PAW = 12,
  parameter int DAW = 12,
  parameter int BRB = 4
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output var logic [31:0] prdata,
  output var logic pready,
  output var logic pslverr,
  // pipeline request
  input wire logic req_valid,
  input wire pds_pkg::pds_kind_t req_kind,
  input wire logic req_byte,
  input wire logic [15:0] req_addr,
  input wire logic [15:0] req_yaddr,
  input wire logic [15:0] req_wdata,
  input wire logic req_fast,
  input wire logic req_rpt,
  input wire logic req_rpt_edge,
  output var logic req_ready,
  // pipeline answer
  output var logic rsp_valid,
  output var logic [15:0] rsp_xdata,
  output var logic [15:0] rsp_ydata
);

  // ----------------------------------------------------------------
  // storage and control state
  // ----------------------------------------------------------------
  logic [23:0] prog_mem [0:(1<<PAW)-1];
  logic [15:0] data_mem [0:(1<<DAW)-1];
  logic [3:0] core_control_reg_r;
  logic [7:0] const_window_page_r;
  logic [7:0] table_page_r;
  logic [15:0] mod_start_r;
  logic [15:0] mod_end_r;
  logic [15:0] win_cnt_r;
  logic last_win_r;
  logic last_inval_r;
  pds_pkg::pds_state_t state_r;
  logic [1:0] wait_r;
  logic [15:0] xdata_hold_r;
  logic [15:0] ydata_hold_r;
  logic acc;
  logic is_tbl;
  logic tbl_wr;
  logic win;
  logic [15:0] x_ea;
  logic [15:0] y_ea;
  wire [15:0] br_ea;
  logic [15:0] w_ea;
  logic [23:0] paddr_w;
  logic p_impl;
  logic [23:0] pw;
  logic [15:0] xres;
  logic [15:0] yres;
  logic inval;
  logic [1:0] extra_nxt;

  assign acc = req_valid & req_ready;
  assign is_tbl = req_kind == pds_pkg::PDS_K_TRL ||
                  req_kind == pds_pkg::PDS_K_TRH ||
                  tbl_wr;
  assign tbl_wr = req_kind == pds_pkg::PDS_K_TWL ||
                  req_kind == pds_pkg::PDS_K_TWH;

  // ----------------------------------------------------------------
  // address helpers
  // ----------------------------------------------------------------
  // circular buffer wrap past the end back to the start
  function automatic logic [15:0] wrap(input logic [15:0] a,
                                       input logic en);
    if (en && a > mod_end_r)
      wrap = mod_start_r + (a - mod_end_r - 16'h0002);
    else
      wrap = a;
  endfunction
  // the y block sits at a fixed place, no register moves it
  function automatic logic in_y(input logic [15:0] a);
    in_y = a >= `PDS_Y_LO && a <= `PDS_Y_HI;
  endfunction
  // word present in the data array
  function automatic logic d_impl(input logic [15:0] a);
    d_impl = a[15:DAW+1] == '0;
  endfunction
  // byte read lands in the low byte, word read whole
  function automatic logic [15:0] lane(input logic [15:0] w,
                                       input logic bsel,
                                       input logic byt);
    if (!byt)
      lane = w;
    else if (bsel)
      lane = {8'h00, w[15:8]};
    else
      lane = {8'h00, w[7:0]};
  endfunction

  // a process, so a new modulo bound re-wraps an address held steady
  always_comb begin
    x_ea = wrap(req_addr, core_control_reg_r[`PDS_CC_XMOD_EN]);
    y_ea = wrap(req_yaddr, core_control_reg_r[`PDS_CC_YMOD_EN]);
  end

  // bit-reversed word index, used only on x writes
  genvar gi;
  generate
    for (gi = 0; gi < BRB; gi++) begin : g_brev
      assign br_ea[gi+1] = x_ea[BRB-gi];
    end
  endgenerate
  assign br_ea[15:BRB+1] = x_ea[15:BRB+1];
  assign br_ea[0] = x_ea[0];
  assign w_ea = core_control_reg_r[`PDS_CC_BREV_EN] ? br_ea : x_ea;

  // ----------------------------------------------------------------
  // program address and word fetch
  // ----------------------------------------------------------------
  // window needs msb and enable, and never during table accesses
  assign win = x_ea[15] & core_control_reg_r[`PDS_CC_WIN_EN] &
               !is_tbl;

  always_comb begin
    if (is_tbl)
      paddr_w = {table_page_r, req_addr};
    else
      paddr_w = {1'b0, const_window_page_r, x_ea[14:0]};
  end

  // bit 0 is byte select; word index steps by two, page top = config
  assign p_impl = paddr_w[23:PAW+1] == '0;
  assign pw = p_impl ? prog_mem[paddr_w[PAW:1]] : 24'h000000;

  // ----------------------------------------------------------------
  // read result forming
  // ----------------------------------------------------------------
  always_comb begin
    xres = 16'h0000;
    yres = 16'h0000;
    inval = 1'b0;
    case (req_kind)
      pds_pkg::PDS_K_TRL: begin
        xres = lane(pw[15:0], req_addr[0], req_byte);
        inval = !p_impl;
      end
      pds_pkg::PDS_K_TRH: begin
        // select one on a byte read is the phantom byte, left at zero
        if (!req_byte || !req_addr[0])
          xres = {8'h00, pw[23:16]};
        inval = !p_impl;
      end
      pds_pkg::PDS_K_DRD: begin
        if (win) begin
          xres = lane(pw[15:0], x_ea[0], req_byte);
          inval = !p_impl;
        end else if (d_impl(x_ea)) begin
          xres = lane(data_mem[x_ea[DAW:1]], x_ea[0], req_byte);
        end else begin
          inval = 1'b1;
        end
      end
      pds_pkg::PDS_K_MAC: begin
        // x side sees data space minus the y block
        if (win) begin
          xres = pw[15:0];
          inval = !p_impl;
        end else if (in_y(x_ea) || !d_impl(x_ea)) begin
          inval = 1'b1;
        end else begin
          xres = data_mem[x_ea[DAW:1]];
        end
        // y pointers reach only the y block
        if (in_y(y_ea) && d_impl(y_ea))
          yres = data_mem[y_ea[DAW:1]];
        else
          inval = 1'b1;
      end
      default: xres = 16'h0000;
    endcase
  end

  // ----------------------------------------------------------------
  // added cycles for window reads
  // ----------------------------------------------------------------
  always_comb begin
    extra_nxt = 2'h0;
    if (win && req_kind != pds_pkg::PDS_K_DWR) begin
      if (req_rpt)
        extra_nxt = req_rpt_edge ? `PDS_RPT_EXTRA_EDGE : 2'h0;
      else if (req_fast || req_kind == pds_pkg::PDS_K_MAC)
        extra_nxt = `PDS_WIN_EXTRA_FAST;
      else
        extra_nxt = `PDS_WIN_EXTRA_SLOW;
    end
  end

  // ----------------------------------------------------------------
  // memory writes
  // ----------------------------------------------------------------
  // every data write uses the single x write path, any implemented address outside the window
  always_ff @(posedge sys_clk) begin
    if (acc && req_kind == pds_pkg::PDS_K_DWR && !win && d_impl(w_ea)) begin
      if (!req_byte)
        data_mem[w_ea[DAW:1]] <= req_wdata;
      else if (w_ea[0])
        data_mem[w_ea[DAW:1]][15:8] <= req_wdata[7:0];
      else
        data_mem[w_ea[DAW:1]][7:0] <= req_wdata[7:0];
    end
  end

  // table writes load one lane; the phantom byte takes nothing
  always_ff @(posedge sys_clk) begin
    if (acc && tbl_wr && p_impl) begin
      if (req_kind == pds_pkg::PDS_K_TWL) begin
        if (!req_byte)
          prog_mem[paddr_w[PAW:1]][15:0] <= req_wdata;
        else if (req_addr[0])
          prog_mem[paddr_w[PAW:1]][15:8] <= req_wdata[7:0];
        else
          prog_mem[paddr_w[PAW:1]][7:0] <= req_wdata[7:0];
      end else if (!req_byte || !req_addr[0]) begin
        prog_mem[paddr_w[PAW:1]][23:16] <= req_wdata[7:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // request sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      state_r <= pds_pkg::PDS_S_IDLE;
      wait_r <= 2'h0;
      req_ready <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_xdata <= 16'h0000;
      rsp_ydata <= 16'h0000;
      xdata_hold_r <= 16'h0000;
      ydata_hold_r <= 16'h0000;
    end else begin
      rsp_valid <= 1'b0;
      case (state_r)
        pds_pkg::PDS_S_IDLE: begin
          req_ready <= 1'b1;
          if (acc) begin
            if (extra_nxt == 2'h0) begin
              rsp_valid <= 1'b1;
              rsp_xdata <= xres;
              rsp_ydata <= yres;
            end else begin
              req_ready <= 1'b0; // stall for the window fetch
              xdata_hold_r <= xres;
              ydata_hold_r <= yres;
              wait_r <= extra_nxt;
              state_r <= pds_pkg::PDS_S_WAIT;
            end
          end
        end
        pds_pkg::PDS_S_WAIT: begin
          wait_r <= wait_r - 2'h1;
          if (wait_r == 2'h1) begin
            rsp_valid <= 1'b1;
            rsp_xdata <= xdata_hold_r;
            rsp_ydata <= ydata_hold_r;
            req_ready <= 1'b1;
            state_r <= pds_pkg::PDS_S_IDLE;
          end
        end
        default: begin
          state_r <= pds_pkg::PDS_S_IDLE;
          req_ready <= 1'b0;
        end
      endcase
    end
  end

  // last access status and window access count
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      last_win_r <= 1'b0;
      last_inval_r <= 1'b0;
      win_cnt_r <= 16'h0000;
    end else if (acc) begin
      last_win_r <= win;
      last_inval_r <= inval;
      if (win)
        win_cnt_r <= win_cnt_r + 16'h0001;
    end
  end

  // ----------------------------------------------------------------
  // apb register file
  // ----------------------------------------------------------------
  logic setup;
  logic mapped;
  assign setup = psel & !penable & !pready;
  always_comb begin
    if (paddr == `PDS_OFS_CORE_CTRL || paddr == `PDS_OFS_WIN_PAGE ||
        paddr == `PDS_OFS_TBL_PAGE)
      mapped = 1'b1;
    else if (paddr == `PDS_OFS_MOD_START || paddr == `PDS_OFS_MOD_END ||
             paddr == `PDS_OFS_STATUS)
      mapped = 1'b1;
    else
      mapped = 1'b0;
  end

  // answer one cycle into the access phase; writes land then
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= setup;
      pslverr <= setup & !mapped;
      if (!setup || pwrite || !mapped)
        prdata <= 32'h0000_0000;
      else if (paddr == `PDS_OFS_CORE_CTRL)
        prdata <= {28'h0000000, core_control_reg_r};
      else if (paddr == `PDS_OFS_WIN_PAGE)
        prdata <= {24'h000000, const_window_page_r};
      else if (paddr == `PDS_OFS_TBL_PAGE)
        prdata <= {24'h000000, table_page_r};
      else if (paddr == `PDS_OFS_MOD_START)
        prdata <= {16'h0000, mod_start_r};
      else if (paddr == `PDS_OFS_MOD_END)
        prdata <= {16'h0000, mod_end_r};
      else
        prdata <= {win_cnt_r, 13'h0000, last_inval_r, last_win_r, !req_ready};
    end
  end

  // software writes taken at the edge that sees pready high
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      core_control_reg_r <= `PDS_CC_RESET;
      const_window_page_r <= `PDS_PAGE_RESET;
      table_page_r <= `PDS_PAGE_RESET;
      mod_start_r <= `PDS_MOD_RESET;
      mod_end_r <= `PDS_MOD_RESET;
    end else if (psel && penable && pready && pwrite) begin
      if (paddr == `PDS_OFS_CORE_CTRL)
        core_control_reg_r <= pwdata[3:0];
      else if (paddr == `PDS_OFS_WIN_PAGE)
        const_window_page_r <= pwdata[7:0];
      else if (paddr == `PDS_OFS_TBL_PAGE)
        table_page_r <= pwdata[7:0];
      else if (paddr == `PDS_OFS_MOD_START)
        mod_start_r <= pwdata[15:0];
      else if (paddr == `PDS_OFS_MOD_END)
        mod_end_r <= pwdata[15:0];
    end
  end

endmodule

`default_nettype wire

// >>> pds_access_assertions.sv
// pds_access_assertions.sv: latency and zero-fill checks on the access ports
// assumes: bound onto pds_access, one clock, synchronous high reset
`timescale 1ns/1ns
`default_nettype none
module pds_access_chk #(
  parameter int DAW = 12
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  // pipeline
  input wire logic req_valid,
  input wire pds_pkg::pds_kind_t req_kind,
  input wire logic req_byte,
  input wire logic [15:0] req_addr,
  input wire logic [15:0] req_yaddr,
  input wire logic req_fast,
  input wire logic req_rpt,
  input wire logic req_rpt_edge,
  input wire logic req_ready,
  input wire logic rsp_valid,
  input wire logic [15:0] rsp_xdata,
  input wire logic [15:0] rsp_ydata
);
  logic win_en_r;
  logic acc;
  logic win;
  logic tbl;
  logic ybk;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  // mirror of the window enable bit, updated when an apb write lands
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      win_en_r <= 1'h0;
    end else if (psel && penable && pready && pwrite && paddr == 8'h00) begin
      win_en_r <= pwdata[0];
    end
  end
  // request classification
  assign acc = req_valid && req_ready;
  assign tbl = req_kind == pds_pkg::PDS_K_TRL || req_kind == pds_pkg::PDS_K_TRH;
  assign win = acc && win_en_r && req_addr[15] &&
    (req_kind == pds_pkg::PDS_K_DRD || req_kind == pds_pkg::PDS_K_MAC);
  assign ybk = req_yaddr >= 16'h1800 && req_yaddr <= 16'h1FFF;
  // answer after one or two idle cycles
  sequence s_gap1;
    !rsp_valid ##1 rsp_valid;
  endsequence
  sequence s_gap2;
    !rsp_valid ##1 !rsp_valid ##1 rsp_valid;
  endsequence
  a_win_slow: assert property (
    win && !req_rpt && !req_fast && req_kind == pds_pkg::PDS_K_DRD |=> s_gap2)
    else $error("slow window read latency wrong");
  a_win_fast: assert property (
    win && !req_rpt && (req_fast || req_kind == pds_pkg::PDS_K_MAC) |=> s_gap1)
    else $error("fast window read latency wrong");
  a_rpt_mid: assert property (win && req_rpt && !req_rpt_edge |=> rsp_valid)
    else $error("repeat middle iteration stalled");
  a_rpt_edge: assert property (win && req_rpt && req_rpt_edge |=> s_gap2)
    else $error("repeat edge iteration latency wrong");
  a_tbl_nowin: assert property (acc && tbl |=> rsp_valid)
    else $error("table read went through window");
  a_win_off: assert property (
    acc && !win_en_r && req_kind == pds_pkg::PDS_K_DRD |=> rsp_valid)
    else $error("window used while disabled");
  a_high_zero: assert property (
    acc && req_kind == pds_pkg::PDS_K_TRH |=> rsp_xdata[15:8] == 8'h00)
    else $error("high table read upper byte not zero");
  a_byte_zero: assert property (acc && tbl && req_byte |=> rsp_xdata[15:8] == 8'h00)
    else $error("table byte read upper byte not zero");
  a_macx_zero: assert property (
    acc && req_kind == pds_pkg::PDS_K_MAC && req_addr >= 16'h1800 &&
    req_addr <= 16'h1FFF |=> rsp_xdata == 16'h0000)
    else $error("mac x pointer into y not zero");
  a_macy_zero: assert property (
    acc && req_kind == pds_pkg::PDS_K_MAC && !ybk && !req_addr[15]
    |=> rsp_ydata == 16'h0000)
    else $error("mac y pointer into x not zero");
endmodule
bind pds_access pds_access_chk #(.DAW(DAW)) pds_access_chk_i (.*);
`default_nettype wire

// >>> pds_pipe_model.sv
// pds_pipe_model.sv: execution pipeline model issuing access requests
// assumes: sys_clk shared with pds_access, caller waits for reset release
`timescale 1ns/1ns
`default_nettype none
module pds_pipe_model (
  // clock
  input wire logic sys_clk,
  // request
  output var logic req_valid,
  output var pds_pkg::pds_kind_t req_kind,
  output var logic req_byte,
  output var logic [15:0] req_addr,
  output var logic [15:0] req_yaddr,
  output var logic [15:0] req_wdata,
  output var logic req_fast,
  output var logic req_rpt,
  output var logic req_rpt_edge,
  input wire logic req_ready,
  // answer
  input wire logic rsp_valid,
  input wire logic [15:0] rsp_xdata,
  input wire logic [15:0] rsp_ydata
);
  // idle request at time zero
  initial begin
    req_valid = 1'h0;
    req_kind = pds_pkg::PDS_K_DRD;
    {req_byte, req_fast, req_rpt, req_rpt_edge} = 4'h0;
    req_addr = 16'h0000;
    req_yaddr = 16'h0000;
    req_wdata = 16'h0000;
  end
  // one request held until taken, then timed to its answer
  // m is {byte, fast, repeat, repeat edge}
  task automatic go(input pds_pkg::pds_kind_t k, input logic [3:0] m,
      input logic [15:0] a, input logic [15:0] y, input logic [15:0] w,
      output logic [15:0] xd, output logic [15:0] yd, output int lat);
    @(posedge sys_clk);
    req_valid <= 1'h1;
    req_kind <= k;
    {req_byte, req_fast, req_rpt, req_rpt_edge} <= m;
    req_addr <= a;
    req_yaddr <= y;
    req_wdata <= w;
    do @(negedge sys_clk); while (req_ready !== 1'h1);
    @(posedge sys_clk);
    // released address and data lines show the inverse, never the last value
    req_valid <= 1'h0;
    req_addr <= ~a;
    req_yaddr <= ~y;
    req_wdata <= ~w;
    lat = 0;
    do begin
      @(negedge sys_clk);
      lat++;
    end while (rsp_valid !== 1'h1);
    xd = rsp_xdata;
    yd = rsp_ydata;
  endtask
endmodule
`default_nettype wire

// >>> tb_top.sv
// tb_top.sv: self-checking bench for the program/data space access block
// assumes: pds_access, pds_pipe_model and the bound checker are compiled
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  localparam pds_pkg::pds_kind_t KDRD = pds_pkg::PDS_K_DRD;
  localparam pds_pkg::pds_kind_t KDWR = pds_pkg::PDS_K_DWR;
  localparam pds_pkg::pds_kind_t KMAC = pds_pkg::PDS_K_MAC;
  localparam pds_pkg::pds_kind_t KTRL = pds_pkg::PDS_K_TRL;
  localparam pds_pkg::pds_kind_t KTRH = pds_pkg::PDS_K_TRH;
  logic sys_clk = 1'h0;
  logic sys_rst = 1'h1;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, req_valid, req_byte, req_fast, req_rpt;
  logic req_rpt_edge, req_ready, rsp_valid;
  pds_pkg::pds_kind_t req_kind;
  logic [15:0] req_addr, req_yaddr, req_wdata, rsp_xdata, rsp_ydata;
  logic [15:0] xd, yd;
  logic [31:0] rd;
  logic er;
  int lat;
  int n_mismatch = 0;
  int checks = 0;
  // 25 MHz clock
  always #20 sys_clk = ~sys_clk;
  pds_access pds_access_i (.*);
  pds_pipe_model pds_pipe_model_i (.*);
  // compare and count
  task automatic chk(input string what, input logic [31:0] seen,
      input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // one apb transfer, held until pready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'h1;
    // held to the rising edge that samples pready; data taken there
    do @(posedge sys_clk); while (pready !== 1'h1);
    rd = prdata;
    er = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  // pipeline request, then a read with data and latency compared
  task automatic op(input pds_pkg::pds_kind_t k, input logic [3:0] m,
      input logic [15:0] a, input logic [15:0] y, input logic [15:0] w);
    pds_pipe_model_i.go(k, m, a, y, w, xd, yd, lat);
  endtask
  task automatic rc(input pds_pkg::pds_kind_t k, input logic [3:0] m,
      input logic [15:0] a, input logic [15:0] e, input int el, string nm);
    op(k, m, a, 16'h0000, 16'h0000);
    chk(nm, xd, e);
    chk(nm, lat, el);
  endtask
  // core control reset value, page register, unmapped offset
  task automatic t_regs();
    apb(1'h0, 8'h00, 32'h0);
    chk("core ctrl reset", rd, 32'h0);
    apb(1'h1, 8'h04, 32'h0000_00A5);
    apb(1'h0, 8'h04, 32'h0);
    chk("window page", rd, 32'h0000_00A5);
    apb(1'h0, 8'h18, 32'h0);
    chk("unmapped err", er, 1'h1);
    chk("unmapped data", rd, 32'h0);
    apb(1'h1, 8'h04, 32'h0);
    $display("t_regs done");
  endtask
  // program words written by table writes, read back through both lanes
  task automatic t_table();
    op(pds_pkg::PDS_K_TWL, 4'h0, 16'h0010, 16'h0000, 16'h1234);
    op(pds_pkg::PDS_K_TWH, 4'h0, 16'h0010, 16'h0000, 16'h00AB);
    op(pds_pkg::PDS_K_TWL, 4'h0, 16'h0012, 16'h0000, 16'h5678);
    op(pds_pkg::PDS_K_TWH, 4'h0, 16'h0012, 16'h0000, 16'h005C);
    rc(KTRL, 4'h0, 16'h0010, 16'h1234, 1, "low word");
    rc(KTRL, 4'h8, 16'h0010, 16'h0034, 1, "low byte0");
    rc(KTRL, 4'h8, 16'h0011, 16'h0012, 1, "low byte1");
    rc(KTRH, 4'h0, 16'h0010, 16'h00AB, 1, "high word");
    rc(KTRH, 4'h8, 16'h0010, 16'h00AB, 1, "high byte0");
    rc(KTRH, 4'h8, 16'h0011, 16'h0000, 1, "high byte1");
    rc(KTRL, 4'h0, 16'h0012, 16'h5678, 1, "next word");
    rc(KTRH, 4'h0, 16'h0012, 16'h005C, 1, "next high");
    apb(1'h1, 8'h08, 32'h0000_0080);
    rc(KTRL, 4'h0, 16'h0010, 16'h0000, 1, "config page");
    apb(1'h1, 8'h08, 32'h0);
    $display("t_table done");
  endtask
  // window reads, latencies, page selection and suspension
  task automatic t_window();
    apb(1'h1, 8'h00, 32'h0000_0001);
    rc(KDRD, 4'h0, 16'h8010, 16'h1234, 3, "win slow");
    rc(KDRD, 4'h4, 16'h8012, 16'h5678, 2, "win fast");
    rc(KMAC, 4'h0, 16'h8010, 16'h1234, 2, "win mac");
    rc(KDRD, 4'h2, 16'h8010, 16'h1234, 1, "rpt mid");
    rc(KDRD, 4'h3, 16'h8010, 16'h1234, 3, "rpt edge");
    rc(KTRL, 4'h0, 16'h8010, 16'h0000, 1, "tbl no win");
    apb(1'h1, 8'h04, 32'h0000_0001);
    rc(KDRD, 4'h0, 16'h8010, 16'h0000, 3, "win page1");
    apb(1'h1, 8'h04, 32'h0);
    apb(1'h1, 8'h00, 32'h0);
    rc(KDRD, 4'h0, 16'h8010, 16'h0000, 1, "win off");
    $display("t_window done");
  endtask
  // writes over the x bus, dual prefetch, wrong-region and unimplemented
  task automatic t_data();
    op(KDWR, 4'h0, 16'h1800, 16'h0000, 16'hBEEF);
    op(KDWR, 4'h0, 16'h0100, 16'h0000, 16'hCAFE);
    rc(KDRD, 4'h0, 16'h1800, 16'hBEEF, 1, "y via x");
    rc(KDRD, 4'h8, 16'h0101, 16'h00CA, 1, "byte hi");
    op(KMAC, 4'h0, 16'h0100, 16'h1800, 16'h0000);
    chk("mac x", xd, 16'hCAFE);
    chk("mac y", yd, 16'hBEEF);
    op(KMAC, 4'h0, 16'h1800, 16'h0100, 16'h0000);
    chk("mac x in y", xd, 16'h0000);
    chk("mac y in x", yd, 16'h0000);
    rc(KDRD, 4'h0, 16'h2000, 16'h0000, 1, "unimpl");
    $display("t_data done");
  endtask
  // status after six windowed reads, circular wrap, bit-reversed write
  task automatic t_mode();
    apb(1'h0, 8'h14, 32'h0);
    chk("status", rd, 32'h0006_0004);
    apb(1'h1, 8'h0C, 32'h0000_0100);
    apb(1'h1, 8'h10, 32'h0000_0102);
    apb(1'h1, 8'h00, 32'h0000_0002);
    rc(KDRD, 4'h0, 16'h0104, 16'hCAFE, 1, "x wrap");
    apb(1'h1, 8'h00, 32'h0000_0008);
    op(KDWR, 4'h0, 16'h0002, 16'h0000, 16'h1111);
    apb(1'h1, 8'h00, 32'h0);
    rc(KDRD, 4'h0, 16'h0010, 16'h1111, 1, "bit reverse");
    $display("t_mode done");
  endtask
  // counts and verdict
  task automatic test_done();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (2) @(posedge sys_clk);
    sys_rst <= 1'h0;
    repeat (3) @(posedge sys_clk);
    t_regs();
    t_table();
    t_window();
    t_data();
    t_mode();
    test_done();
  end
  // watchdog, far beyond the 130 or so cycles the tests need
  initial begin
    repeat (20000) @(posedge sys_clk);
    n_mismatch++;
    test_done();
  end
endmodule
`default_nettype wire
